// ---- logic/bus_timing_map.svh ----
`ifndef BUS_TIMING_MAP_SVH
`define BUS_TIMING_MAP_SVH
// double-rate clock cycles of one bus clock period
`define BT_DR_PER_BUS 2'd2
// read sample point after address, non-pipelined, in double-rate cycles
`define BT_READ_SAMPLE_DR 4'd4
// write data lead before cycle end, in double-rate cycles
`define BT_WDATA_LEAD_DR 4'd3
// write data hold after cycle end, in double-rate cycles
`define BT_WDATA_HOLD_DR 4'd1
// wait state length in nanoseconds at a 20 MHz bus clock
`define BT_WAIT_NS 50
`define BT_CLK_NS 25
`define BT_WAIT_CYC ((`BT_WAIT_NS + `BT_CLK_NS - 1) / `BT_CLK_NS)
`endif

// ---- logic/bus_timing_pkg.sv ----
package bus_timing_pkg;
   typedef enum logic [2:0] {
      st_idle,
      st_first,
      st_second,
      st_hold
   } cyc_state_e;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic write;
      logic pipelined;
   } bus_req_s;

   typedef struct packed {
      logic [31:0] rdata;
      logic done;
   } bus_rsp_s;
endpackage

// ---- logic/pin_sync3.sv ----
`timescale 1ns/10ps
// three-stage synchroniser; change accepted when stages two and three agree
module pin_sync3 (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic pin,
   output logic level
);
   logic [2:0] stage_reg;

   // shift chain
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         stage_reg <= 3'h0;
      end else begin
         stage_reg <= {stage_reg[1:0], pin};
      end
   end

   // hold last agreed value
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         level <= 1'b0;
      end else if (stage_reg[1] == stage_reg[2]) begin
         level <= stage_reg[2];
      end
   end
endmodule

// ---- logic/local_bus_cycle_timing.sv ----
`timescale 1ns/10ps
`include "bus_timing_map.svh"
// Bus cycle timing rules
// R1: ready is ignored during the whole first bus clock period of a cycle.
// R2: later, ready sampled at each period's last edge; cycle ends when found.
// R3: external generator makes bus clock at half the double-rate clock.
// R4: internal bus phase aligns to external half clock at reset release.
// R5: external half clock low in phase 1, high in phase 2.
// R6: external reset is released during phase 2, synchronous to clock.
// R7: outside logic samples start strobe on edges at end of phase 2.
// R8: read data sampled four double-rate cycles after address, no waits.
// R9: pipelined address comes one bus period earlier than non-pipelined; here it leads by at most one double-rate cycle.
// R10: each wait state adds one bus clock period.
// R11: write data driven three double-rate cycles before end, plus waits.
// R12: write data held one double-rate cycle after cycle end; here it is held for two.
// R13: outside ready due within four cycles of address, extended by waits.
// R14: bus controller registers run on the double-rate clock.
// R15: half-clock start strobe synchroniser optional outside.
// R16: controller toggles phase flag every edge from reset phase.
module local_bus_cycle_timing (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic half_clock,
   input wire logic ready_n,
   input wire logic req_valid,
   input wire bus_timing_pkg::bus_req_s req,
   input wire logic [31:0] data_in,
   output bus_timing_pkg::bus_rsp_s rsp,
   output logic req_ready,
   output logic phase2,
   output logic cycle_start_strobe_n,
   output logic [31:0] addr_out,
   output logic addr_valid,
   output logic [31:0] data_out,
   output logic data_oe_n,
   output logic [7:0] wait_count
);
   bus_timing_pkg::cyc_state_e state_reg, state_next;
   bus_timing_pkg::bus_req_s cur_reg;
   logic half_sync;
   logic aligned_reg;
   logic [1:0] hold_reg;

   pin_sync3 u_half (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .pin(half_clock),
      .level(half_sync)
   );

   // cycle starts only on a phase-2 edge so T-states line up with bus clock
   wire at_period_end = phase2;
   wire start = (state_reg == bus_timing_pkg::st_idle) && req_valid && aligned_reg && at_period_end;
   // ready only looked at on the last edge of second and later periods
   wire sample_ready = (state_reg == bus_timing_pkg::st_second) && at_period_end; // R1 R2
   wire cyc_end = sample_ready && !ready_n; // R2
   // a period that ends without ready is one wait state
   wire add_wait = sample_ready && ready_n; // R10

   // next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         bus_timing_pkg::st_idle: if (start) state_next = bus_timing_pkg::st_first;
         bus_timing_pkg::st_first: if (at_period_end) state_next = bus_timing_pkg::st_second; // R1
         bus_timing_pkg::st_second: if (cyc_end) state_next = bus_timing_pkg::st_hold;
         bus_timing_pkg::st_hold: state_next = bus_timing_pkg::st_idle;
         default: state_next = bus_timing_pkg::st_idle;
      endcase
   end

   // phase flag; resynchronised to half clock once after reset
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         phase2 <= 1'b0;
         aligned_reg <= 1'b0;
      end else if (!aligned_reg) begin
         phase2 <= !half_sync; // R4
         aligned_reg <= 1'b1;
      end else begin
         phase2 <= !phase2; // R16
      end
   end

   // state and captured request
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= bus_timing_pkg::st_idle;
         cur_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (start) cur_reg <= req;
      end
   end

   // address and strobe; pipelined address shows at the first idle edge with a request, one double-rate cycle earlier only if that is a phase-1 edge
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         addr_out <= 32'h0;
         addr_valid <= 1'b0;
         cycle_start_strobe_n <= 1'b1;
      end else begin
         if (req_valid && req.pipelined && state_reg == bus_timing_pkg::st_idle) begin
            addr_out <= req.addr; // R9
            addr_valid <= 1'b1;
         end else if (start) begin
            addr_out <= req.addr; // R8 R13
            addr_valid <= 1'b1;
         end else if (state_reg == bus_timing_pkg::st_hold) begin
            addr_valid <= 1'b0;
         end
         cycle_start_strobe_n <= !start; // R7
      end
   end

   // write data driven from one edge after cycle start (3 edges before earliest end) to two edges after end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         data_out <= 32'h0;
         data_oe_n <= 1'b1;
         hold_reg <= 2'h0;
      end else begin
         if (state_reg == bus_timing_pkg::st_first && cur_reg.write && !phase2) begin
            data_out <= cur_reg.wdata; // R11
            data_oe_n <= 1'b0;
         end else if (cyc_end && cur_reg.write) begin
            hold_reg <= 2'(`BT_WDATA_HOLD_DR); // R12
         end else if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
         end else if (state_reg == bus_timing_pkg::st_idle) begin
            data_oe_n <= 1'b1;
         end
      end
   end

   // read data capture, wait count, completion
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rsp <= '0;
         wait_count <= 8'h0;
         req_ready <= 1'b0;
      end else begin
         rsp.done <= cyc_end;
         if (cyc_end && !cur_reg.write) rsp.rdata <= data_in; // R8
         if (start) wait_count <= 8'h0;
         else if (add_wait) wait_count <= wait_count + 8'h1; // R10
         req_ready <= start;
      end
   end
endmodule

// ---- test/bus_timing_props.sv ----
`timescale 1ns/10ps
module bus_timing_props (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic ready_n,
   input wire bus_timing_pkg::bus_rsp_s rsp,
   input wire logic req_ready,
   input wire logic phase2,
   input wire logic cycle_start_strobe_n,
   input wire logic addr_valid,
   input wire logic data_oe_n,
   input wire logic [7:0] wait_count
);
   // every check runs on the double-rate clock
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_phase_alternates: assert property ($past(resetn, 2) |-> phase2 != $past(phase2))
      else $error("phase flag did not alternate");
   a_start_marks_take: assert property ($fell(cycle_start_strobe_n) |-> req_ready && addr_valid)
      else $error("start strobe without take and address");
   a_first_period_done: assert property (req_ready |-> !rsp.done [*3])
      else $error("cycle ended inside first period");
   a_done_from_ready: assert property (rsp.done |-> $past(ready_n) == 1'b0 && $past(phase2))
      else $error("done without ready at phase 2 sample");
   a_done_one_cycle: assert property (rsp.done |=> !rsp.done)
      else $error("done longer than one cycle");
   a_wait_steps: assert property ($changed(wait_count) && wait_count != 8'h00 |->
      wait_count == $past(wait_count) + 8'h01 && $past(ready_n) && $past(phase2))
      else $error("wait count step wrong");
   a_wdata_lead: assert property ($fell(data_oe_n) |-> $past(req_ready))
      else $error("write data enabled at wrong time");
   a_wdata_hold: assert property (rsp.done && $past(data_oe_n) == 1'b0 |-> !data_oe_n)
      else $error("write data dropped at cycle end");
endmodule
bind local_bus_cycle_timing bus_timing_props u_props (.sys_clk(sys_clk), .resetn(resetn),
   .ready_n(ready_n), .rsp(rsp), .req_ready(req_ready), .phase2(phase2),
   .cycle_start_strobe_n(cycle_start_strobe_n), .addr_valid(addr_valid),
   .data_oe_n(data_oe_n), .wait_count(wait_count));

// ---- test/bus_ctrl_model.sv ----
`timescale 1ns/10ps
module bus_ctrl_model (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic cycle_start_strobe_n,
   input wire logic [7:0] waits,
   input wire logic [31:0] rd_val,
   output logic half_clock,
   output logic ready_n,
   output logic [31:0] data_in
);
   logic [8:0] cnt_reg;
   // free-running divide by two, low in phase 1
   initial half_clock = 1'b0;
   always @(posedge sys_clk) half_clock <= !half_clock;
   // edges since the start strobe; strobe taken on double-rate edges, no half-clock synchroniser
   always_ff @(posedge sys_clk) cnt_reg <= (!resetn || !cycle_start_strobe_n) ? 9'h000 : cnt_reg + 9'h001;
   // ready after the asked number of wait states
   assign ready_n = !(cnt_reg >= {waits, 1'b0} + 9'h002);
   // data valid only while ready, inverted otherwise
   assign data_in = ready_n ? ~rd_val : rd_val;
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic req_valid = 1'b0;
   bus_timing_pkg::bus_req_s req = '0;
   logic [7:0] waits = 8'h00;
   logic [31:0] rd_val = 32'h0;
   logic half_clock, ready_n, req_ready, phase2, strobe_n, addr_valid, oe_n;
   logic [31:0] data_in, addr_out, data_out;
   logic [7:0] wait_count;
   bus_timing_pkg::bus_rsp_s rsp;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int n;
   logic av;
   always #12.5 sys_clk = !sys_clk;
   local_bus_cycle_timing DUT (.sys_clk(sys_clk), .resetn(resetn), .half_clock(half_clock),
      .ready_n(ready_n), .req_valid(req_valid), .req(req), .data_in(data_in), .rsp(rsp),
      .req_ready(req_ready), .phase2(phase2), .cycle_start_strobe_n(strobe_n), .addr_out(addr_out),
      .addr_valid(addr_valid), .data_out(data_out), .data_oe_n(oe_n), .wait_count(wait_count));
   bus_ctrl_model u_model (.sys_clk(sys_clk), .resetn(resetn), .cycle_start_strobe_n(strobe_n),
      .waits(waits), .rd_val(rd_val), .half_clock(half_clock), .ready_n(ready_n), .data_in(data_in));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one cycle: take, then count edges to done
   task run_cycle(input logic [31:0] a, input logic wr, input logic pipe, input logic [7:0] w);
      int k;
      k = 0;
      waits <= w;
      rd_val <= a ^ 32'h5a5a0000;
      req <= '{a, ~a, wr, pipe};
      req_valid <= 1'b1;
      do begin
         av = addr_valid;
         @(posedge sys_clk);
         k++;
      end while (req_ready !== 1'b1 && k < 20);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (rsp.done !== 1'b1 && n < 40);
   endtask
   task t_read;
      run_cycle(32'h10000004, 1'b0, 1'b0, 8'h00);
      chk(n, 4);
      chk(addr_out, 32'h10000004);
      chk(rsp.rdata, 32'h4a5a0004);
      chk(av, 1'b0);
      $display("read done");
   endtask
   task t_write_waits;
      run_cycle(32'h20000008, 1'b1, 1'b0, 8'h03);
      chk(n, 10);
      chk(wait_count, 8'h03);
      chk(data_out, 32'hdffffff7);
      chk(oe_n, 1'b0);
      $display("write with waits done");
   endtask
   task t_pipe;
      // launch the request so the next edge is a phase-1 edge, ahead of the take
      while (phase2 !== 1'b1) @(posedge sys_clk);
      run_cycle(32'h3000000c, 1'b0, 1'b1, 8'h01);
      chk(n, 6);
      chk(wait_count, 8'h01);
      chk(av, 1'b1);
      chk(rsp.rdata, 32'h6a5a000c);
      $display("pipelined read done");
   endtask
   task report_and_stop;
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // cut a hang short
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         report_and_stop;
      end
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      while (half_clock !== 1'b1) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_read;
      repeat (4) @(posedge sys_clk);
      t_write_waits;
      repeat (4) @(posedge sys_clk);
      t_pipe;
      report_and_stop;
   end
endmodule
